// File: include/cds_div_if.sv
// Purpose: Carries sync requests and settings from the control logic to the divider.
// Assumes: Both ends run on clk_sys_in.
// Notes: tick and synced are one-cycle pulses from the divider.
`timescale 1ns/1ps
interface cds_div_if;
  logic sync_req;
  logic [2:0] phase;
  logic [2:0] ratio;
  logic tick;
  logic synced;

  modport ctrl (output sync_req, output phase, output ratio, input tick, input synced);
  modport div (input sync_req, input phase, input ratio, output tick, output synced);
endinterface

// File: include/cds_pkg.sv
// Purpose: Types shared by the divider sync control modules.
// Assumes: Field widths of three bits for phase and ratio.
// Notes: Offsets and constants live in cds_regs.svh.
package cds_pkg;

  typedef enum logic {
    CDS_RUN,
    CDS_DELAY
  } cds_div_mode_t;

  typedef struct packed {
    cds_div_mode_t mode;
    logic [2:0] cnt;
    logic [2:0] dly;
    logic tick;
    logic synced;
  } cds_div_state_t;

  typedef struct packed {
    logic master;
    logic div_en;
    logic one_shot;
    logic [2:0] phase;
    logic [2:0] ratio;
    logic sync_q;
    logic sync_qq;
    logic sync_req;
    logic aligned;
    logic [7:0] sync_cnt;
    logic [7:0] rdata;
    logic rvalid;
    logic tick;
  } cds_ctrl_state_t;

endpackage

// File: include/cds_regs.svh
// Purpose: Register offsets, field positions and reset values of the divider sync control block.
// Assumes: 13-bit register addresses on the configuration port, 8-bit register data.
// Notes: Included by cds_sync_ctrl; the package holds only the types.
`ifndef CDS_REGS_SVH
`define CDS_REGS_SVH

`define CDS_ADDR_W 13
`define CDS_DATA_W 8

`define CDS_SYNC_CTRL_ADDR 13'h100
`define CDS_PHASE_ADDR 13'h016
`define CDS_DIV_RATIO_ADDR 13'h00b
`define CDS_STATUS_ADDR 13'h101
`define CDS_SYNC_CNT_ADDR 13'h102

`define CDS_MASTER_BIT 0
`define CDS_DIV_EN_BIT 1
`define CDS_ONE_SHOT_BIT 2
`define CDS_PHASE_LSB 0
`define CDS_PHASE_MSB 2
`define CDS_RATIO_LSB 0
`define CDS_RATIO_MSB 2
`define CDS_ALIGNED_BIT 0
`define CDS_PENDING_BIT 1

`define CDS_SYNC_CTRL_RST 8'h00
`define CDS_PHASE_RST 3'h0
`define CDS_RATIO_RST 3'h0

`endif

// File: rtl/cds_divider.sv
// Purpose: Integer input-clock divider that realigns on a sync request with a programmed phase delay.
// Assumes: ratio N divides by N+1; phase is the delay in input clock cycles.
// Notes: tick is a one-cycle enable pulse at the divided rate.
`timescale 1ns/1ps
module cds_divider
  import cds_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Link to the control logic
  cds_div_if.div dif
);

  cds_div_state_t s_r;
  cds_div_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.synced = 1'b0;
    if (dif.sync_req) begin
      if (dif.phase == 3'h0) begin // RQ7
        s_nxt.cnt = 3'h0;
        s_nxt.tick = 1'b1;
        s_nxt.synced = 1'b1;
        s_nxt.mode = CDS_RUN;
      end else begin
        s_nxt.dly = dif.phase; // RQ7
        s_nxt.mode = CDS_DELAY;
      end
    end else begin
      case (s_r.mode)
        CDS_DELAY: begin
          if (s_r.dly == 3'h1) begin
            s_nxt.cnt = 3'h0;
            s_nxt.tick = 1'b1;
            s_nxt.synced = 1'b1;
            s_nxt.mode = CDS_RUN;
          end else begin
            s_nxt.dly = s_r.dly - 3'h1;
          end
        end
        CDS_RUN: begin
          if (s_r.cnt >= dif.ratio) begin
            s_nxt.cnt = 3'h0;
            s_nxt.tick = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 3'h1;
          end
        end
        default: s_nxt.mode = CDS_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{mode: CDS_RUN, cnt: 3'h0, dly: 3'h0, tick: 1'b0, synced: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dif.tick = s_r.tick;
  assign dif.synced = s_r.synced;

endmodule // cds_divider

// File: rtl/cds_sync_ctrl.sv
// Purpose: Sync control register and sync pulse gating for the input-clock divider.
// Assumes: All inputs are synchronous to clk_sys_in; register port is a simple strobe port.
// Notes: Read data appears one cycle after the read strobe with reg_rvalid_out.
//
// Functional notes
// (RQ1) All sync functions are ignored unless master sync enable bit 0 is high.
// (RQ2) Software keeps master enable low when sync is unused, saving power.
// (RQ3) Sync pulses reach the divider only while divider sync enable bit 1 is high.
// (RQ4) Both enables high, one-shot off: every sync pulse resynchronizes the divider.
// (RQ5) One-shot bit 2 set: only the first pulse aligns the divider, later ones ignored.
// (RQ6) In one-shot mode the divider sync enable clears itself after syncing.
// (RQ7) After sync the divider phase is delayed zero to seven input clocks.
// (RQ8) The sync input is registered and acted on at its rising edge only.
`timescale 1ns/1ps
`include "cds_regs.svh"
module cds_sync_ctrl
  import cds_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // External sync pulse
  input wire logic sync_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`CDS_ADDR_W-1:0] reg_addr_in,
  input wire logic [`CDS_DATA_W-1:0] reg_wdata_in,
  output logic [`CDS_DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Divider and power outputs
  output logic div_tick_out,
  output logic sync_power_en_out
);

  cds_ctrl_state_t s_r;
  cds_ctrl_state_t s_nxt;
  cds_div_if dif ();
  logic sync_rise;
  logic pulse_ok;

  cds_divider u_divider (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .dif(dif)
  );

  assign dif.sync_req = s_r.sync_req;
  assign dif.phase = s_r.phase;
  assign dif.ratio = s_r.ratio;

  // A level held high across many cycles must count as one pulse.
  assign sync_rise = s_r.sync_q & ~s_r.sync_qq; // RQ8
  assign pulse_ok = s_r.master & s_r.div_en & sync_rise; // RQ1 RQ3 RQ4

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.sync_req = 1'b0;
    s_nxt.tick = dif.tick;
    s_nxt.sync_q = sync_in; // RQ8
    s_nxt.sync_qq = s_r.sync_q;

    if (pulse_ok) begin
      s_nxt.sync_req = 1'b1; // RQ4
      s_nxt.sync_cnt = s_r.sync_cnt + 8'h01;
      // Clearing the enable at once keeps any later pulse away from the divider.
      if (s_r.one_shot) begin
        s_nxt.div_en = 1'b0; // RQ5 RQ6
      end
    end

    // A software write in the same cycle as the self-clear wins, so a re-arm is never lost.
    if (reg_wr_in) begin
      case (reg_addr_in)
        `CDS_SYNC_CTRL_ADDR: begin
          s_nxt.master = reg_wdata_in[`CDS_MASTER_BIT];
          s_nxt.div_en = reg_wdata_in[`CDS_DIV_EN_BIT];
          s_nxt.one_shot = reg_wdata_in[`CDS_ONE_SHOT_BIT];
          if (reg_wdata_in[`CDS_DIV_EN_BIT]) begin
            s_nxt.aligned = 1'b0;
          end
        end
        `CDS_PHASE_ADDR: begin
          s_nxt.phase = reg_wdata_in[`CDS_PHASE_MSB:`CDS_PHASE_LSB]; // RQ7
        end
        `CDS_DIV_RATIO_ADDR: begin
          s_nxt.ratio = reg_wdata_in[`CDS_RATIO_MSB:`CDS_RATIO_LSB];
        end
        `CDS_SYNC_CNT_ADDR: begin
          s_nxt.sync_cnt = 8'h00;
        end
        default: begin
        end
      endcase
    end

    // Placed after the write so that a sync landing with a re-arm write still shows as aligned.
    if (dif.synced) begin
      s_nxt.aligned = 1'b1;
    end

    if (reg_rd_in) begin
      s_nxt.rvalid = 1'b1;
      case (reg_addr_in)
        `CDS_SYNC_CTRL_ADDR: begin
          s_nxt.rdata = {5'h00, s_r.one_shot, s_r.div_en, s_r.master};
        end
        `CDS_PHASE_ADDR: begin
          s_nxt.rdata = {5'h00, s_r.phase};
        end
        `CDS_DIV_RATIO_ADDR: begin
          s_nxt.rdata = {5'h00, s_r.ratio};
        end
        `CDS_STATUS_ADDR: begin
          s_nxt.rdata = {6'h00, s_r.sync_req, s_r.aligned};
        end
        `CDS_SYNC_CNT_ADDR: begin
          s_nxt.rdata = s_r.sync_cnt;
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_out = s_r.rdata;
  assign reg_rvalid_out = s_r.rvalid;
  assign div_tick_out = s_r.tick;
  // Sync circuitry elsewhere may be powered down while this is low.
  assign sync_power_en_out = s_r.master; // RQ2

endmodule // cds_sync_ctrl

// File: test/cds_sync_ctrl_asserts.sv
// Purpose: Port checks of cds_sync_ctrl.
// Assumes: One clock, async active-low reset.
// Notes: Bound to every cds_sync_ctrl.
`timescale 1ns/1ps
module cds_sync_ctrl_asserts (
  // Inputs
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic sync_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [12:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // Outputs
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic div_tick_out,
  input wire logic sync_power_en_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic cw;
  logic um;
  assign cw = reg_wr_in && reg_addr_in == 13'h100;
  assign um = !(reg_addr_in inside {13'h100, 13'h016, 13'h00b, 13'h101, 13'h102});
  property p_rv; reg_rd_in |=> reg_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_nrv; !reg_rd_in |=> !reg_rvalid_out; endproperty
  a_nrv: assert property (p_nrv) else $error("stray rvalid");
  property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_rsv; reg_rd_in && reg_addr_in == 13'h100 |=> reg_rdata_out[7:3] == 5'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_um; reg_rd_in && um |=> reg_rdata_out == 8'h00; endproperty
  a_um: assert property (p_um) else $error("unmapped read");
  // Bit 1 may self-clear through a one-shot sync between the write and the read.
  property p_wrd; cw ##1 !reg_wr_in ##1 (reg_rd_in && reg_addr_in == 13'h100) |=>
    reg_rdata_out[2] == $past(reg_wdata_in[2], 3) && reg_rdata_out[0] == $past(reg_wdata_in[0], 3) &&
    (!reg_rdata_out[1] || $past(reg_wdata_in[1], 3));
  endproperty
  a_wrd: assert property (p_wrd) else $error("control readback");
  property p_pwr; cw ##1 !reg_wr_in |=> sync_power_en_out == $past(reg_wdata_in[0], 2); endproperty
  a_pwr: assert property (p_pwr) else $error("power enable");
  property p_pst; !reg_wr_in && !$past(reg_wr_in) |=> $stable(sync_power_en_out); endproperty
  a_pst: assert property (p_pst) else $error("power enable moved");
  c_sync: cover property ($rose(sync_in) && sync_power_en_out);
  c_wrd: cover property (cw ##2 reg_rd_in);
  c_tick: cover property (div_tick_out ##1 !div_tick_out);
endmodule // cds_sync_ctrl_asserts
bind cds_sync_ctrl cds_sync_ctrl_asserts u_chk (.clk_sys_in, .resetn_in, .sync_in, .reg_wr_in, .reg_rd_in,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .div_tick_out, .sync_power_en_out);

// File: test/cds_sync_ctrl_tb.sv
// Purpose: Self-checking bench of cds_sync_ctrl.
// Assumes: 100 MHz clock.
// Notes: Row loop, then sync cases.
`timescale 1ns/1ps
module cds_sync_ctrl_tb;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sync_in;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [12:0] reg_addr_in = 13'h000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out, div_tick_out, sync_power_en_out;
  int error_cnt = 0;
  int n_checks = 0;
  logic [12:0] rows [6][3] = '{'{13'h100, 13'hff, 13'h07}, '{13'h016, 13'h05, 13'h05}, '{13'h00b, 13'h02, 13'h02},
    '{13'h0c5, 13'haa, 13'h00}, '{13'h102, 13'h33, 13'h00}, '{13'h100, 13'h00, 13'h00}};
  logic [7:0] modes [4][3] = '{'{8'h02, 8'h00, 8'h02}, '{8'h01, 8'h00, 8'h01}, '{8'h07, 8'h01, 8'h05},
    '{8'h03, 8'h02, 8'h03}};
  always #5 clk_sys_in = ~clk_sys_in;
  cds_sync_src src (.clk_sys_in, .sync_out(sync_in));
  cds_sync_ctrl dut (.clk_sys_in, .resetn_in, .sync_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_rvalid_out, .div_tick_out, .sync_power_en_out);
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in) reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    @(posedge clk_sys_in) reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in) reg_rd_in <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid_out}, 8'h01);
    chk(reg_rdata_out, e);
  endtask
  // Ratio 3 gives a tick every fourth cycle once realigned.
  task automatic tick_at(input int p);
    repeat (2 + p) @(posedge clk_sys_in);
    #1 chk({7'h00, div_tick_out}, 8'h01);
    repeat (3) @(posedge clk_sys_in) #1 chk({7'h00, div_tick_out}, 8'h00);
    @(posedge clk_sys_in) #1 chk({7'h00, div_tick_out}, 8'h01);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000 error_cnt++;
    close_out();
  end
  initial begin
    repeat (19) @(posedge clk_sys_in);
    #1 chk({reg_rdata_out[4:0], reg_rvalid_out, div_tick_out, sync_power_en_out}, 8'h00);
    @(posedge clk_sys_in) resetn_in <= 1'b1;
    rd(13'h100, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1][7:0]);
      rd(rows[i][0], rows[i][2][7:0]);
    end
    $display("test registers done");
    wr(13'h00b, 8'h03);
    for (int p = 0; p < 8; p += 7) begin
      wr(13'h016, p[7:0]);
      wr(13'h100, 8'h03);
      src.fire();
      tick_at(p);
    end
    rd(13'h101, 8'h01);
    $display("test phase done");
    foreach (modes[i]) begin
      wr(13'h102, 8'h00);
      wr(13'h100, modes[i][0]);
      src.fire();
      src.fire();
      rd(13'h102, modes[i][1]);
      rd(13'h100, modes[i][2]);
      chk({7'h00, sync_power_en_out}, {7'h00, modes[i][0][0]});
    end
    wr(13'h100, 8'h00);
    repeat (2) @(posedge clk_sys_in);
    #1 chk({7'h00, sync_power_en_out}, 8'h00);
    $display("test modes done");
    // Reset in mid-run must drop phase, ratio and count set by the earlier tests.
    @(posedge clk_sys_in) resetn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1 chk({reg_rdata_out[4:0], reg_rvalid_out, div_tick_out, sync_power_en_out}, 8'h00);
    @(posedge clk_sys_in) resetn_in <= 1'b1;
    rd(13'h016, 8'h00);
    rd(13'h00b, 8'h00);
    rd(13'h102, 8'h00);
    chk({7'h00, div_tick_out}, 8'h01);
    $display("test reset done");
    close_out();
  end
endmodule // cds_sync_ctrl_tb

// File: test/cds_sync_src.sv
// Purpose: External sync pulse source.
// Assumes: Pulses launch on clk_sys_in edges.
// Notes: Two cycles high, then low.
`timescale 1ns/1ps
module cds_sync_src (
  // Clock
  input wire logic clk_sys_in,
  // Sync line
  output logic sync_out
);
  initial sync_out = 1'b0;
  // The low time after each pulse lets every rising edge be seen.
  task automatic fire();
    @(posedge clk_sys_in) sync_out <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sync_out <= 1'b0;
  endtask
endmodule // cds_sync_src
